//--- bench/timer_output_compare_pwm_properties.sv
// Port assertions for the output compare and PWM block
`timescale 1ns/1ps
module timer_output_compare_pwm_properties
    import tocpwm_pkg::*;
(
    input wire logic               clk_sys,
    input wire logic               reset_n,
    input wire logic               timer_tick,
    input wire logic               counter_run,
    input wire logic               counter_clear,
    input wire logic [CNT_W-1:0]   modulo_value,
    input wire logic               overflow_irq_enable,
    input wire logic [2:0]         pair_link,
    input wire logic [5:0]         single_mode,
    input wire logic [5:0]         edge_level_select_high,
    input wire logic [5:0]         edge_level_select_low,
    input wire logic [5:0]         toggle_on_overflow,
    input wire logic [5:0]         max_duty_force,
    input wire logic [5:0]         channel_irq_enable,
    input wire logic [CNT_W-1:0]   counter_value,
    input wire logic [95:0]        channel_compare_value,
    input wire logic               overflow_flag,
    input wire logic               overflow_irq,
    input wire logic [5:0]         channel_event_flag,
    input wire logic [5:0]         channel_irq,
    input wire logic [5:0]         channel_pin_out,
    input wire logic [5:0]         channel_pin_oe,
    input wire logic [2:0]         pair_odd_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire [CNT_W-1:0] next_count = (counter_value == modulo_value) ? 16'h0000 : counter_value + 16'h0001;
    logic ovf_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) ovf_reg <= 1'b0;
        else ovf_reg <= timer_tick && counter_run && !counter_clear && counter_value == modulo_value;
    end
    sequence ovf_s;
        timer_tick && counter_run && !counter_clear && counter_value == modulo_value;
    endsequence
    sequence m0_s;
        timer_tick && counter_run && !counter_clear && single_mode[0] && !pair_link[0] && !max_duty_force[0]
            && next_count == channel_compare_value[15:0];
    endsequence
    chk_count_wrap: assert property (ovf_s |=> counter_value == 16'h0000)
        else $error("counter did not wrap at modulo");
    chk_count_step: assert property (timer_tick && counter_run && !counter_clear && counter_value != modulo_value
        |=> counter_value == $past(counter_value) + 16'h0001) else $error("counter did not advance");
    chk_ovf_flag: assert property (ovf_s |=> overflow_flag)
        else $error("overflow flag not set");
    chk_ovf_irq: assert property (overflow_irq == (overflow_flag && overflow_irq_enable))
        else $error("overflow request wrong");
    chk_ch_flag: assert property (m0_s |=> channel_event_flag[0])
        else $error("channel flag not set on match");
    chk_ch_irq: assert property (channel_irq[0] == (channel_event_flag[0] && channel_irq_enable[0]))
        else $error("channel request wrong");
    chk_pin_edge: assert property ((m0_s and edge_level_select_high[0])
        |=> channel_pin_out[0] == $past(edge_level_select_low[0])) else $error("compare pin action wrong");
    chk_pin_toggle: assert property ((ovf_s and single_mode[0] && !pair_link[0] && toggle_on_overflow[0]
        && !max_duty_force[0] && edge_level_select_high[0] && next_count != channel_compare_value[15:0])
        |=> channel_pin_out[0] != $past(channel_pin_out[0])) else $error("overflow toggle missing");
    chk_odd_free: assert property (pair_link[0] |-> !channel_pin_oe[1])
        else $error("odd pin still driven");
    chk_buf_switch: assert property (pair_link[0] && $past(pair_link[0]) && $changed(pair_odd_active[0])
        |-> ovf_reg) else $error("buffer switched off overflow");
    chk_max_duty: assert property ((single_mode[0] && !pair_link[0] && max_duty_force[0] && toggle_on_overflow[0]
        && edge_level_select_high[0] && !edge_level_select_low[0]) [*3] |-> channel_pin_out[0])
        else $error("full duty not held");
endmodule // timer_output_compare_pwm_properties
bind timer_output_compare_pwm timer_output_compare_pwm_properties chk_inst (.*);

//--- bench/timer_output_compare_pwm_test.sv
// Self-checking bench for the output compare and PWM block
`timescale 1ns/1ps
module timer_output_compare_pwm_test
    import tocpwm_pkg::*;
;
    logic clk_sys = 1'b0, reset_n = 1'b0, timer_tick = 1'b0, counter_run = 1'b0, counter_clear = 1'b0;
    logic overflow_irq_enable = 1'b0, overflow_flag_clear = 1'b0, overflow_flag, overflow_irq;
    logic [15:0] modulo_value = 16'h000F, value_wr_data = 16'h0000, counter_value, d;
    logic [2:0] pair_link = 3'h0, pair_odd_active;
    logic [5:0] single_mode = 6'h00, edge_level_select_high = 6'h00, edge_level_select_low = 6'h00;
    logic [5:0] toggle_on_overflow = 6'h00, max_duty_force = 6'h00, channel_irq_enable = 6'h00;
    logic [5:0] channel_flag_clear = 6'h00, value_wr_en = 6'h00;
    logic [5:0] channel_event_flag, channel_irq, channel_pin_out, channel_pin_oe;
    logic [95:0] channel_compare_value;
    int failures = 0, n_compared = 0, hi, lo, t, ch;
    timer_output_compare_pwm timer_output_compare_pwm_inst (.*);
    always #12.5 clk_sys = ~clk_sys;
    function automatic int period(input logic [15:0] m);
        return int'(m) + 1;
    endfunction
    function automatic int duty_hi(input int v, input int m);
        return 32 * v / (m + 1);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input int c, input logic [15:0] v);
        @(posedge clk_sys);
        value_wr_en <= 6'h01 << c;
        value_wr_data <= v;
        @(posedge clk_sys);
        value_wr_en <= 6'h00;
        #1;
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        t = 0;
        do begin
            @(posedge clk_sys);
            #1;
            t++;
        end while (counter_value !== v && t < 5000);
        check("count reached", counter_value, v);
    endtask
    task automatic clr;
        @(posedge clk_sys);
        channel_flag_clear <= 6'h3F;
        overflow_flag_clear <= 1'b1;
        @(posedge clk_sys);
        channel_flag_clear <= 6'h00;
        overflow_flag_clear <= 1'b0;
        #1;
        check("flags cleared", {overflow_flag, channel_event_flag[0]}, 2'h0);
    endtask
    task automatic pwm_run(input logic [15:0] v);
        wr(0, v);
        repeat (2) wait_cnt(16'h0000);
        hi = 0;
        repeat (32) begin
            hi += int'(channel_pin_out[0]);
            @(posedge clk_sys);
            #1;
        end
    endtask
    initial begin
        #500000;
        failures++;
        end_sim;
    end
    initial begin
        void'($urandom(90));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 24; i++) begin
            ch = $urandom_range(5);
            d = 16'($urandom);
            wr(ch, d);
            check("value", channel_compare_value[ch*16+:16], d);
        end
        single_mode <= 6'h01;
        edge_level_select_high <= 6'h01;
        toggle_on_overflow <= 6'h01;
        timer_tick <= 1'b1;
        counter_run <= 1'b1;
        pwm_run(16'h0004);
        lo = hi;
        check("duty", lo, duty_hi(4, int'(modulo_value)));
        wait_cnt(16'h0000);
        check("period", t, period(modulo_value));
        pwm_run(16'h0009);
        check("duty step", hi - lo, duty_hi(9, int'(modulo_value)) - duty_hi(4, int'(modulo_value)));
        edge_level_select_low <= 6'h01;
        pwm_run(16'h0004);
        check("set polarity", hi, 32 - duty_hi(4, int'(modulo_value)));
        edge_level_select_low <= 6'h00;
        check("flags", {overflow_flag, channel_event_flag[0], channel_irq[0]}, 3'h6);
        channel_irq_enable <= 6'h01;
        overflow_irq_enable <= 1'b1;
        modulo_value <= 16'h003F;
        wr(0, 16'h0032);
        check("irqs", {overflow_irq, channel_irq[0]}, 2'h3);
        wait_cnt(16'h0014);
        clr;
        wr(0, 16'h000A);
        wait_cnt(16'h003E);
        check("late lower", channel_event_flag[0], 1'b0);
        wait_cnt(16'h001E);
        clr;
        wr(0, 16'h0028);
        wait_cnt(16'h002D);
        check("second match", channel_event_flag[0], 1'b1);
        clr;
        wr(0, 16'h0010);
        wait_cnt(16'h003E);
        check("sync lower", channel_event_flag[0], 1'b0);
        wait_cnt(16'h0014);
        check("next period", channel_event_flag[0], 1'b1);
        pair_link <= 3'h1;
        single_mode <= 6'h03;
        edge_level_select_high <= 6'h03;
        wr(1, 16'h0020);
        check("odd released", {channel_pin_oe[1], channel_pin_oe[0], pair_odd_active[0]}, 3'h2);
        wait_cnt(16'h0001);
        check("odd active", pair_odd_active[0], 1'b1);
        wr(0, 16'h0010);
        wait_cnt(16'h0001);
        check("even active", pair_odd_active[0], 1'b0);
        pair_link <= 3'h0;
        max_duty_force <= 6'h01;
        pwm_run(16'h0010);
        check("full duty", hi, 32);
        toggle_on_overflow <= 6'h00;
        pwm_run(16'h0010);
        check("zero duty", hi, 0);
        max_duty_force <= 6'h00;
        edge_level_select_high <= 6'h00;
        edge_level_select_low <= 6'h01;
        pwm_run(16'h0010);
        check("compare toggle", hi, 16);
        @(posedge clk_sys);
        counter_clear <= 1'b1;
        @(posedge clk_sys);
        counter_clear <= 1'b0;
        #1;
        check("clear", counter_value, CNT_RESET);
        end_sim;
    end
endmodule // timer_output_compare_pwm_test

//--- rtl/chan_if.sv
// Bundle of per-channel compare signals passed to the channel bank
`timescale 1ns/1ps
interface chan_if #(parameter int N = 6, parameter int W = 16);
    logic [N-1:0][W-1:0] wr_value;
    logic [N-1:0]        wr_en;
    logic [N-1:0][W-1:0] value;
    modport bank (input wr_value, input wr_en, output value);
    modport user (output wr_value, output wr_en, input value);
endinterface

//--- rtl/chan_value_bank.sv
// Channel compare value storage, one register per channel
`timescale 1ns/1ps
module chan_value_bank
    import tocpwm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    chan_if.bank      ch
);
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_val
            logic [CNT_W-1:0] value_reg;
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    value_reg <= CNT_RESET;
                end else if (ch.wr_en[i]) begin
                    value_reg <= ch.wr_value[i];
                end
            end
            assign ch.value[i] = value_reg;
        end
    endgenerate
endmodule // chan_value_bank

//--- rtl/timer_output_compare_pwm.sv
// Output compare and PWM logic for six channels of a 16-bit modulo timer
`timescale 1ns/1ps
// Contract
// - Unbuffered channel compares directly against its written value, no holding stage.
// - Compare fires only on counter equal to channel value.
// - Value lowered below count before match gives no compare that period.
// - Channel compare request raised on counter match.
// - Overflow request raised when counter reaches modulo.
// - Value raised above count after compare fires again same period.
// - Pair-link bit on even channel joins it with next odd channel.
// - Even value controls first; last written register controls from next overflow.
// - While linked, even control bits govern; odd control bits ignored.
// - While linked, odd pin released for general-purpose use.
// - Writing the active pair register takes effect immediately.
// - Toggle-on-overflow toggles pin when counter reaches modulo.
// - With edge select high set, compare clears pin if edge select low is 0, sets if 1.
// - PWM period is modulo plus one prescaled clocks.
// - Duty equals compare value over period count.
// - Channel flag set per compare; request only when channel enable set.
// - Overflow flag set at modulo; request only when overflow enable set.
// - Pair-link bit has priority over single-channel mode bit.
// - Max duty with toggle-on-overflow gives 100%; without, 0%.
module timer_output_compare_pwm
    import tocpwm_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    timer_tick,
    input  wire logic                    counter_run,
    input  wire logic                    counter_clear,
    input  wire logic [CNT_W-1:0]        modulo_value,
    input  wire logic                    overflow_irq_enable,
    input  wire logic                    overflow_flag_clear,
    input  wire logic [NUM_PAIRS-1:0]    pair_link,
    input  wire logic [NUM_CH-1:0]       single_mode,
    input  wire logic [NUM_CH-1:0]       edge_level_select_high,
    input  wire logic [NUM_CH-1:0]       edge_level_select_low,
    input  wire logic [NUM_CH-1:0]       toggle_on_overflow,
    input  wire logic [NUM_CH-1:0]       max_duty_force,
    input  wire logic [NUM_CH-1:0]       channel_irq_enable,
    input  wire logic [NUM_CH-1:0]       channel_flag_clear,
    input  wire logic [NUM_CH-1:0]       value_wr_en,
    input  wire logic [CNT_W-1:0]        value_wr_data,
    output logic [CNT_W-1:0]             counter_value,
    output logic [NUM_CH*CNT_W-1:0]      channel_compare_value,
    output logic                         overflow_flag,
    output logic                         overflow_irq,
    output logic [NUM_CH-1:0]            channel_event_flag,
    output logic [NUM_CH-1:0]            channel_irq,
    output logic [NUM_CH-1:0]            channel_pin_out,
    output logic [NUM_CH-1:0]            channel_pin_oe,
    output logic [NUM_PAIRS-1:0]         pair_odd_active
);
    initial begin
        if (NUM_CH != 2 * NUM_PAIRS) $error("Channel count must be twice the pair count");
        if (NUM_PAIRS < 1) $error("At least one channel pair is needed");
        if (CNT_W != 16) $error("Compare path is built for a 16-bit counter");
    end

    logic                   rst_meta_reg;
    logic                   rst_n_reg;
    logic [CNT_W-1:0]       count_reg;
    logic                   ovf_flag_reg;
    logic [NUM_CH-1:0]      ch_flag_reg;
    logic [NUM_CH-1:0]      pin_reg;
    logic [NUM_PAIRS-1:0]   odd_active_reg;
    logic [NUM_PAIRS-1:0]   odd_written_reg;

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Compare value registers, one per channel
    chan_if #(.N(NUM_CH), .W(CNT_W)) ch ();

    chan_value_bank u_bank (
        .clk_sys (clk_sys),
        .rst_n   (rst_n_reg),
        .ch      (ch.bank)
    );

    // Write steering and flattened value outputs
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_wr
            assign ch.wr_value[i] = value_wr_data;
            assign ch.wr_en[i]    = value_wr_en[i];
            assign channel_compare_value[i*CNT_W +: CNT_W] = ch.value[i];
        end
    endgenerate

    // Counter and overflow
    wire tick_run  = timer_tick && counter_run;
    // A clear overrides the step, so no compare is taken from a cleared count
    wire cnt_step  = tick_run && !counter_clear;
    wire at_modulo = (count_reg == modulo_value);
    wire ovf_event = tick_run && at_modulo;
    wire [CNT_W-1:0] count_next = at_modulo ? CNT_RESET : count_reg + 16'h0001;

    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            count_reg <= CNT_RESET;
        end else if (counter_clear) begin
            count_reg <= CNT_RESET;
        end else if (tick_run) begin
            count_reg <= count_next;
        end
    end

    // Sticky overflow flag, set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ovf_flag_reg <= 1'b0;
        end else if (ovf_event) begin
            ovf_flag_reg <= 1'b1;
        end else if (overflow_flag_clear) begin
            ovf_flag_reg <= 1'b0;
        end
    end

    // Pair selection: active register follows the last write, switching at overflow
    generate
        for (i = 0; i < NUM_PAIRS; i++) begin : g_pair
            wire odd_wr  = value_wr_en[2*i+1];
            wire even_wr = value_wr_en[2*i];
            wire last_odd = odd_wr ? 1'b1 : (even_wr ? 1'b0 : odd_written_reg[i]);
            always_ff @(posedge clk_sys or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    odd_written_reg[i] <= 1'b0;
                    odd_active_reg[i]  <= 1'b0;
                end else if (!pair_link[i]) begin
                    odd_written_reg[i] <= 1'b0;
                    odd_active_reg[i]  <= 1'b0;
                end else begin
                    odd_written_reg[i] <= last_odd;
                    if (ovf_event) begin
                        odd_active_reg[i] <= last_odd;
                    end
                end
            end
        end
    endgenerate

    // Per-channel compare and pin logic
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            localparam int P = i / 2;
            localparam bit ODD = (i % 2) == 1;
            wire linked   = pair_link[P];
            wire odd_idle = ODD && linked;
            wire [CNT_W-1:0] cmp_val = (!ODD && linked && odd_active_reg[P]) ? ch.value[2*P+1] : ch.value[i];
            wire active_mode = linked || single_mode[i] || (ODD && single_mode[i]);
            wire out_mode = !odd_idle && (ODD ? single_mode[i] : active_mode);
            wire [1:0] els = {edge_level_select_high[i], edge_level_select_low[i]};
            // Match as the counter steps onto the value, so duty is value over period
            wire match = cnt_step && (count_next == cmp_val);
            wire cmp_event = out_mode && match;
            wire ovf_tog = out_mode && ovf_event && toggle_on_overflow[i];
            wire max_level = toggle_on_overflow[i] ? !edge_level_select_low[i] : edge_level_select_low[i];
            wire flag_drop = channel_flag_clear[i] || odd_idle;
            logic pin_next;

            // Max duty overrides compare; compare wins over the overflow toggle
            always_comb begin
                pin_next = pin_reg[i];
                if (max_duty_force[i]) begin
                    pin_next = max_level;
                end else if (cmp_event) begin
                    unique case (els)
                        ELS_TOGGLE: pin_next = !pin_reg[i];
                        ELS_CLEAR:  pin_next = 1'b0;
                        ELS_SET:    pin_next = 1'b1;
                        ELS_OFF:    pin_next = pin_reg[i];
                    endcase
                end else if (ovf_tog) begin
                    pin_next = !pin_reg[i];
                end
            end

            // Pin level register
            always_ff @(posedge clk_sys or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    pin_reg[i] <= 1'b0;
                end else if (out_mode) begin
                    pin_reg[i] <= pin_next;
                end
            end

            // Sticky channel flag, set wins over clear
            always_ff @(posedge clk_sys or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    ch_flag_reg[i] <= 1'b0;
                end else if (cmp_event) begin
                    ch_flag_reg[i] <= 1'b1;
                end else if (flag_drop) begin
                    ch_flag_reg[i] <= 1'b0;
                end
            end

            // Pin drive enable and channel request
            assign channel_pin_oe[i] = out_mode && (els != ELS_OFF);
            assign channel_irq[i]    = ch_flag_reg[i] && channel_irq_enable[i] && !odd_idle;
        end
    endgenerate

    // Top-level outputs
    assign counter_value      = count_reg;
    assign overflow_flag      = ovf_flag_reg;
    assign overflow_irq       = ovf_flag_reg && overflow_irq_enable;
    assign channel_event_flag = ch_flag_reg;
    assign channel_pin_out    = pin_reg;
    assign pair_odd_active    = odd_active_reg;
endmodule // timer_output_compare_pwm

//--- rtl/tocpwm_pkg.sv
// Constants shared by the output compare and PWM block
package tocpwm_pkg;
    localparam int CNT_W        = 16;
    localparam int NUM_CH       = 6;
    localparam int NUM_PAIRS    = 3;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] MOD_RESET  = 16'hFFFF;
    // Edge/level select field encodings (high bit, low bit)
    localparam logic [1:0] ELS_OFF    = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR  = 2'h2;
    localparam logic [1:0] ELS_SET    = 2'h3;
endpackage
